/* File: rtl/mfs_pkg.sv */
// Shared constants, register map and types of the motor fault and speed command block.
package mfs_pkg;
	// ==========================================================
	// Register map
	localparam logic [7:0] FAULT_ADDR  = 8'h00; // Fault flags, read only.
	localparam logic [7:0] STATUS_ADDR = 8'h01; // Lock method and lockout state, read only.
	localparam logic [7:0] CONFIG_ADDR = 8'h02; // Source, minimum duty and ramp control.
	localparam logic [7:0] ILIMIT_ADDR = 8'h03; // Software current limit on the duty.
	localparam logic [7:0] SPEED_ADDR  = 8'h30; // Serial speed command and its select bit.
	// Field positions.
	localparam int TSD_BIT    = 15;
	localparam int WARN_BIT   = 14;
	localparam int OC_BIT     = 11;
	localparam int SEL_BIT    = 15;
	localparam int UVLO_BIT   = 3;
	localparam int OFF_BIT    = 4;
	localparam int CFG_PWM    = 2;
	localparam int CFG_ACCEL  = 3;
	// Reset values.
	localparam logic [3:0] CONFIG_RESET = 4'h8;
	localparam logic [8:0] ILIMIT_RESET = 9'h1ff;
	// ==========================================================
	// Duty scale and modulator
	localparam int         DUTY_W    = 9;
	localparam logic [8:0] PWM_TOP   = 9'h1fe; // Last carrier count, 511 counts per period.
	localparam logic [8:0] MIN_DUTY  = 9'h033; // Minimum PWM command, about ten percent.
	localparam logic [8:0] MIN_OFF   = 9'h01a; // Below this the command is treated as off.
	localparam logic [8:0] ACCEL_STEP = 9'h004; // Largest rise of peak duty per period.
	localparam logic [3:0] POS_LAST  = 4'hf;   // Sixteen steps of 7.5 degrees per sector.
	localparam logic [1:0] SECT_LAST = 2'h2;   // Three sectors of 120 degrees.
	localparam logic [4:0] P1_OFFS   = 5'h08;  // Sixty degrees ahead of the second phase.
	localparam int         SIN_SHIFT = 8;
	// ==========================================================
	// Pins and timing
	localparam int PIN_TSD = 0;  // Junction above the shutdown threshold.
	localparam int PIN_REL = 1;  // Junction below shutdown threshold minus hysteresis.
	localparam int PIN_WRN = 2;  // Junction above the warning threshold.
	localparam int PIN_UVF = 3;  // Supply at or below the falling lockout threshold.
	localparam int PIN_UVR = 4;  // Supply above the rising lockout threshold.
	localparam int PIN_OC  = 5;  // Phase current above the overcurrent threshold.
	localparam int PIN_PWM = 6;  // Digital level of the speed pin.
	localparam int PIN_AVS = 7;  // Voltage surge guard request.
	localparam int PIN_LCK = 8;  // Three lock detection methods from here.
	localparam int LOCK_N  = 3;
	localparam int PIN_W   = 11;
	localparam int CLK_PERIOD_NS = 20;
	localparam int LOCK_CNT_W    = 24;

	typedef enum logic {MODE_RUN, MODE_OFF} mfs_mode_t;

	// Sine of n times 7.5 degrees, full scale 255, n from 0 to 24.
	function automatic logic [7:0] mfs_sin(input logic [4:0] n);
		logic [4:0] m;
		m = (n > 5'd12) ? 5'd24 - n : n;
		case (m)
			5'd0:    mfs_sin = 8'h00;
			5'd1:    mfs_sin = 8'h21;
			5'd2:    mfs_sin = 8'h42;
			5'd3:    mfs_sin = 8'h62;
			5'd4:    mfs_sin = 8'h80;
			5'd5:    mfs_sin = 8'h9b;
			5'd6:    mfs_sin = 8'hb4;
			5'd7:    mfs_sin = 8'hca;
			5'd8:    mfs_sin = 8'hdd;
			5'd9:    mfs_sin = 8'hec;
			5'd10:   mfs_sin = 8'hf6;
			5'd11:   mfs_sin = 8'hfd;
			default: mfs_sin = 8'hff;
		endcase
	endfunction : mfs_sin
endpackage : mfs_pkg

/* File: rtl/mfs_pin_if.sv */
// Bundle of raw and synchronised status pins between the pin filter and the core.
`timescale 1ns/1ps
interface mfs_pin_if;
	logic [mfs_pkg::PIN_W-1:0] raw;
	logic [mfs_pkg::PIN_W-1:0] clean;
	modport src  (output raw);
	modport filt (input raw, output clean);
	modport core (input clean);
endinterface : mfs_pin_if

/* File: rtl/mfs_pin_sync.sv */
// Three-stage synchroniser with agreement filter for the asynchronous status pins.
`timescale 1ns/1ps
module mfs_pin_sync (
	input  wire logic clk,
	input  wire logic rst_b,
	mfs_pin_if.filt   pins
);
	import mfs_pkg::*;

	typedef struct packed {
		logic [PIN_W-1:0] s1;
		logic [PIN_W-1:0] s2;
		logic [PIN_W-1:0] s3;
		logic [PIN_W-1:0] clean;
	} mfs_sync_t;

	mfs_sync_t st;
	mfs_sync_t next_st;

	// Shift the pins in; a bit changes only when the second and third stages agree.
	always_comb begin
		next_st       = st;
		next_st.s1    = pins.raw;
		next_st.s2    = st.s1;
		next_st.s3    = st.s2;
		next_st.clean = (~(st.s2 ^ st.s3) & st.s2) | ((st.s2 ^ st.s3) & st.clean);
	end

	// State register.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign pins.clean = st.clean;
endmodule : mfs_pin_sync

/* File: rtl/mfs_core.sv */
// Fault supervision, lock retry, speed command selection and sinusoidal phase modulator.
`timescale 1ns/1ps
module mfs_core #(
	parameter int unsigned LOCK_OFF_US = 1000
) (
	input  wire logic                           clk,
	input  wire logic                           rst_b,
	input  wire logic [mfs_pkg::PIN_W-1:0]      status_pins,
	input  wire logic [mfs_pkg::DUTY_W-1:0]     speed_level,
	input  wire logic [7:0]                     reg_addr,
	input  wire logic                           reg_wr,
	input  wire logic                           reg_rd,
	input  wire logic [15:0]                    reg_wdata,
	output logic      [15:0]                    reg_rdata,
	output logic      [2:0]                     phase_hi,
	output logic      [2:0]                     phase_oe
);
	import mfs_pkg::*;

	localparam int unsigned LOCK_OFF_CYC = (LOCK_OFF_US * 1000) / CLK_PERIOD_NS;
	localparam logic [LOCK_CNT_W-1:0] LOCK_OFF_LAST = LOCK_CNT_W'(LOCK_OFF_CYC - 1);

	typedef struct packed {
		logic                  tsd;
		logic                  warn;
		logic                  uvlo;
		logic                  ocf;
		logic [LOCK_N-1:0]     lock_method;
		mfs_mode_t             mode;
		logic [LOCK_CNT_W-1:0] off_cnt;
		logic [3:0]            cfg;
		logic [8:0]            ilimit;
		logic [8:0]            serial_speed;
		logic                  serial_sel;
		logic [8:0]            carrier;
		logic [8:0]            pwm_high;
		logic [8:0]            pwm_duty;
		logic [8:0]            peak;
		logic [1:0]            sector;
		logic [3:0]            pos;
		logic [8:0]            cmp1;
		logic [8:0]            cmp2;
		logic [2:0]            phase_hi;
		logic [2:0]            phase_oe;
		logic [15:0]           rdata;
	} mfs_core_t;

	mfs_core_t  st;
	mfs_core_t  next_st;
	mfs_pin_if  pins ();
	logic [8:0] cmd;

	// Pins cross into this clock through the three-stage filter.
	assign pins.raw = status_pins;
	mfs_pin_sync u_sync (
		.clk   (clk),
		.rst_b (rst_b),
		.pins  (pins.filt)
	);

	// ==========================================================
	// Next-state logic
	always_comb begin
		logic [8:0]  pin_cmd;
		logic [8:0]  req;
		logic [16:0] prod1;
		logic [16:0] prod2;
		logic [15:0] word;
		logic        drive;
		logic        per_end;
		logic [4:0]  idx2;
		next_st = st;
		drive   = 1'b0;
		pin_cmd = '0;
		req     = '0;
		word    = '0;
		idx2    = {1'b0, st.pos};
		prod1   = st.peak * mfs_sin(idx2 + P1_OFFS);
		prod2   = st.peak * mfs_sin(idx2);
		per_end = (st.carrier == PWM_TOP);
		// thermal shutdown hysteresis; setting wins over release.
		if (pins.clean[PIN_TSD]) begin
			next_st.tsd = 1'b1;
		end else if (pins.clean[PIN_REL]) begin
			next_st.tsd = 1'b0;
		end
		next_st.warn = pins.clean[PIN_WRN];
		if (pins.clean[PIN_UVF]) begin
			next_st.uvlo = 1'b1;
		end else if (pins.clean[PIN_UVR]) begin
			next_st.uvlo = 1'b0;
		end
		// Overcurrent and lock stop the drive and start one lock-off wait.
		case (st.mode)
			MODE_RUN: begin
				if (pins.clean[PIN_OC]) begin
					next_st.ocf     = 1'b1;
					next_st.mode    = MODE_OFF;
					next_st.off_cnt = LOCK_OFF_LAST;
				end else if (|pins.clean[PIN_LCK +: LOCK_N]) begin
					next_st.lock_method = pins.clean[PIN_LCK +: LOCK_N];
					next_st.mode        = MODE_OFF;
					next_st.off_cnt     = LOCK_OFF_LAST;
				end
			end
			MODE_OFF: begin
				if (st.off_cnt == '0) begin
					next_st.mode        = MODE_RUN;
					next_st.ocf         = pins.clean[PIN_OC];
					next_st.lock_method = pins.clean[PIN_LCK +: LOCK_N];
				end else begin
					next_st.off_cnt     = st.off_cnt - 1'b1;
					next_st.ocf         = st.ocf | pins.clean[PIN_OC];
					next_st.lock_method = st.lock_method | pins.clean[PIN_LCK +: LOCK_N];
				end
			end
			default: begin
				next_st.mode = MODE_RUN;
			end
		endcase
		// drive only when no lockout, shutdown or lock-off.
		drive = (st.mode == MODE_RUN) && !st.tsd && !st.uvlo;
		// minimum duty of the PWM input.
		case (st.cfg[1:0])
			2'h0:    pin_cmd = st.pwm_duty;
			2'h1:    pin_cmd = (st.pwm_duty < MIN_DUTY) ? MIN_DUTY : st.pwm_duty;
			2'h2:    pin_cmd = (st.pwm_duty < MIN_DUTY) ? 9'h000 : st.pwm_duty;
			default: pin_cmd = (st.pwm_duty < MIN_OFF) ? 9'h000 :
				(st.pwm_duty < MIN_DUTY) ? MIN_DUTY : st.pwm_duty;
		endcase
		// one source of the speed command.
		if (st.serial_sel) begin
			cmd = st.serial_speed;
		end else if (st.cfg[CFG_PWM]) begin
			cmd = pin_cmd;
		end else begin
			cmd = speed_level;
		end
		req = (cmd > st.ilimit) ? st.ilimit : cmd;
		// Carrier, PWM input duty capture and electrical angle.
		next_st.carrier  = per_end ? 9'h000 : st.carrier + 1'b1;
		next_st.pwm_high = per_end ? 9'h000 : st.pwm_high + {8'h00, pins.clean[PIN_PWM]};
		if (per_end) begin
			next_st.pwm_duty = st.pwm_high + {8'h00, pins.clean[PIN_PWM]};
			next_st.pos      = st.pos + 1'b1;
			if (st.pos == POS_LAST) begin
				next_st.sector = (st.sector == SECT_LAST) ? 2'h0 : st.sector + 1'b1;
			end
			// peak duty scales both modulated phases.
			next_st.cmp1 = prod1[SIN_SHIFT +: DUTY_W];
			next_st.cmp2 = prod2[SIN_SHIFT +: DUTY_W];
			// surge guard holds and ramp limits any rise.
			if (!drive) begin
				next_st.peak = 9'h000;
			end else if (req <= st.peak) begin
				next_st.peak = req;
			end else if (pins.clean[PIN_AVS]) begin
				next_st.peak = st.peak;
			end else if (st.cfg[CFG_ACCEL] && (req - st.peak > ACCEL_STEP)) begin
				next_st.peak = st.peak + ACCEL_STEP;
			end else begin
				next_st.peak = req;
			end
		end
		// one phase held low per sector, other two modulated.
		case (st.sector)
			2'h0:    next_st.phase_hi = {1'b0, st.carrier < st.cmp2, st.carrier < st.cmp1};
			2'h1:    next_st.phase_hi = {st.carrier < st.cmp2, st.carrier < st.cmp1, 1'b0};
			default: next_st.phase_hi = {st.carrier < st.cmp1, 1'b0, st.carrier < st.cmp2};
		endcase
		if (!drive) begin
			next_st.phase_hi = 3'h0;
		end
		next_st.phase_oe = {3{drive}};
		// Register writes.
		if (reg_wr) begin
			case (reg_addr)
				SPEED_ADDR: begin
					next_st.serial_speed = reg_wdata[8:0];
					next_st.serial_sel   = reg_wdata[SEL_BIT];
				end
				CONFIG_ADDR: next_st.cfg    = reg_wdata[3:0];
				ILIMIT_ADDR: next_st.ilimit = reg_wdata[8:0];
				default:     next_st.cfg    = st.cfg;
			endcase
		end
		case (reg_addr)
			FAULT_ADDR: begin
				word[TSD_BIT]  = st.tsd;
				word[WARN_BIT] = st.warn;
				word[OC_BIT]   = st.ocf;
			end
			STATUS_ADDR: begin
				word[LOCK_N-1:0] = st.lock_method;
				word[UVLO_BIT]   = st.uvlo;
				word[OFF_BIT]    = (st.mode == MODE_OFF);
			end
			CONFIG_ADDR: word[3:0] = st.cfg;
			ILIMIT_ADDR: word[8:0] = st.ilimit;
			SPEED_ADDR: begin
				word[8:0]     = st.serial_speed;
				word[SEL_BIT] = st.serial_sel;
			end
			default: word = 16'h0000;
		endcase
		if (reg_rd) begin
			next_st.rdata = word;
		end
	end

	// State register.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st        <= '0;
			st.uvlo   <= 1'b1;
			st.cfg    <= CONFIG_RESET;
			st.ilimit <= ILIMIT_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign reg_rdata = st.rdata;
	assign phase_hi  = st.phase_hi;
	assign phase_oe  = st.phase_oe;

	// ==========================================================
	// Assertions
	// shutdown flag set.
	tsd_flag_a: assert property (@(posedge clk) disable iff (!rst_b) pins.clean[PIN_TSD] |=> st.tsd) else $error("Shutdown flag not set.");
	warn_flag_a: assert property (@(posedge clk) disable iff (!rst_b) pins.clean[PIN_WRN] && !st.warn |=> st.warn ##1 (st.warn || !$past(pins.clean[PIN_WRN]))) else $error("Warning flag lost.");
	// no release without the release pin.
	tsd_hold_a: assert property (@(posedge clk) disable iff (!rst_b) st.tsd && !pins.clean[PIN_REL] |=> st.tsd) else $error("Shutdown released early.");
	uvlo_hold_a: assert property (@(posedge clk) disable iff (!rst_b) st.uvlo && !pins.clean[PIN_UVR] |=> st.uvlo) else $error("Lockout released early.");
	oc_hiz_a: assert property (@(posedge clk) disable iff (!rst_b) (st.mode == MODE_RUN) && pins.clean[PIN_OC] |=> (st.mode == MODE_OFF) ##1 (phase_oe == 3'h0)) else $error("Overcurrent did not release phases.");
	oc_flag_a: assert property (@(posedge clk) disable iff (!rst_b) pins.clean[PIN_OC] |=> st.ocf) else $error("Overcurrent flag not set.");
	lock_stop_a: assert property (@(posedge clk) disable iff (!rst_b) (st.mode == MODE_RUN) && !pins.clean[PIN_OC] && |pins.clean[PIN_LCK +: LOCK_N] |=> (st.mode == MODE_OFF) && (st.lock_method != '0)) else $error("Lock not recorded.");
	lock_retry_a: assert property (@(posedge clk) disable iff (!rst_b) (st.mode == MODE_OFF) && (st.off_cnt == '0) |=> (st.mode == MODE_RUN)) else $error("No restart after lock-off.");
	halt_hiz_a: assert property (@(posedge clk) disable iff (!rst_b) st.uvlo || st.tsd |=> (phase_oe == 3'h0) && (phase_hi == 3'h0)) else $error("Phases driven in lockout.");
	serial_sel_a: assert property (@(posedge clk) disable iff (!rst_b) st.serial_sel |-> (cmd == st.serial_speed)) else $error("Serial command not selected.");
endmodule : mfs_core

/* File: test/mfs_motor_model.sv */
// Behavioural model of the motor windings and the speed command source.
`timescale 1ns/1ps
module mfs_motor_model (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic [2:0] phase_hi,
	input  wire logic [2:0] phase_oe,
	input  wire logic       short_en,
	input  wire logic       blocked,
	input  wire logic [2:0] lock_sel,
	input  wire logic [8:0] pwm_duty,
	output logic            oc_pin,
	output logic [2:0]      lock_pins,
	output logic            speed_pin
);
	logic [8:0] cnt;

	// A shorted winding draws current only while some phase is driven.
	assign oc_pin = short_en & (|phase_oe);
	// A blocked rotor keeps the chosen lock detectors asserted.
	assign lock_pins = blocked ? lock_sel : 3'h0;
	// The speed source makes a 511-count PWM pattern of the given duty.
	assign speed_pin = (cnt < pwm_duty);

	// Carrier of the speed source, free running like a host timer.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= 9'h000;
		end else begin
			cnt <= (cnt == 9'h1fe) ? 9'h000 : cnt + 9'h001;
		end
	end
endmodule : mfs_motor_model

/* File: test/tb.sv */
// Self-checking testbench of the motor fault and speed command block.
`timescale 1ns/1ps
module tb;
	import mfs_pkg::*;
	logic        clk, rst_b, reg_wr, reg_rd;
	logic [7:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata, d;
	logic [8:0]  speed_level, pwm_duty;
	logic [2:0]  phase_hi, phase_oe, lock_sel, lock_pins;
	logic        tsd, rel, wrn, uvf, uvr, voltage_surge_guard, short_en, blocked, oc_pin, speed_pin;
	logic [10:0] status_pins;
	int          failures, num_checks, sine_bad;

	assign status_pins = {lock_pins, voltage_surge_guard, speed_pin, oc_pin, uvr, uvf, wrn, rel, tsd};

	mfs_core #(.LOCK_OFF_US(1)) dut_u (.clk(clk), .rst_b(rst_b), .status_pins(status_pins),
		.speed_level(speed_level), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .phase_hi(phase_hi), .phase_oe(phase_oe));

	mfs_motor_model motor_u (.clk(clk), .rst_b(rst_b), .phase_hi(phase_hi),
		.phase_oe(phase_oe), .short_en(short_en), .blocked(blocked), .lock_sel(lock_sel),
		.pwm_duty(pwm_duty), .oc_pin(oc_pin), .lock_pins(lock_pins), .speed_pin(speed_pin));

	// ==========================================================
	// Clock and helpers
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// While all phases drive, one of them must stay low.
	always @(negedge clk) begin
		if (rst_b && phase_oe === 3'b111 && phase_hi === 3'b111) sine_bad++;
	end

	task end_of_test;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_of_test

	task chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task wt(input int n);
		repeat (n) @(posedge clk);
	endtask : wt

	task wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		chk(reg_rdata, exp);
		@(posedge clk);
	endtask : rd

	// Compares the driver enables where they are settled, then returns on a rising edge.
	task chk_oe(input logic [2:0] exp);
		@(negedge clk);
		chk(16'(phase_oe), 16'(exp));
		@(posedge clk);
	endtask : chk_oe

	// Waits for all three drivers to come back, bounded.
	task wait_oe;
		int n;
		n = 0;
		@(negedge clk);
		while (phase_oe !== 3'b111 && n < 3000) begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
		num_checks++;
		if (n >= 3000) begin
			failures++;
			$display("MISMATCH %0t drivers never re-enabled", $time);
			end_of_test();
		end
	endtask : wait_oe

	// ==========================================================
	// Main sequence
	initial begin
		rst_b = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 16'h0000;
		speed_level = 9'h100; pwm_duty = 9'h0c0; tsd = 1'b0; rel = 1'b1; wrn = 1'b0;
		uvf = 1'b0; uvr = 1'b1; voltage_surge_guard = 1'b0; short_en = 1'b0; blocked = 1'b0;
		lock_sel = 3'h0; failures = 0; num_checks = 0; sine_bad = 0;
		wt(6);
		rst_b <= 1'b1;
		wait_oe();
		rd(CONFIG_ADDR, 16'h0008);
		rd(ILIMIT_ADDR, 16'h01ff);
		rd(8'h55, 16'h0000);
		wr(FAULT_ADDR, 16'hffff);
		rd(FAULT_ADDR, 16'h0000);
		for (int m = 0; m < 4; m++) begin
			wr(CONFIG_ADDR, 16'h000c | 16'(m));
			rd(CONFIG_ADDR, 16'h000c | 16'(m));
		end
		wr(CONFIG_ADDR, 16'h0008);
		wr(SPEED_ADDR, 16'h8123);
		rd(SPEED_ADDR, 16'h8123);
		wr(SPEED_ADDR, 16'h0000);
		wt(1200);
		// Thermal shutdown, warning and hysteresis release.
		tsd <= 1'b1;
		rel <= 1'b0;
		wt(8);
		rd(FAULT_ADDR, 16'h8000);
		chk_oe(3'h0);
		wrn <= 1'b1;
		tsd <= 1'b0;
		wt(8);
		rd(FAULT_ADDR, 16'hc000);
		wrn <= 1'b0;
		rel <= 1'b1;
		wt(8);
		rd(FAULT_ADDR, 16'h0000);
		wait_oe();
		wrn <= 1'b1;
		wt(8);
		rd(FAULT_ADDR, 16'h4000);
		wrn <= 1'b0;
		// Under-voltage lockout with its two thresholds.
		uvf <= 1'b1;
		uvr <= 1'b0;
		wt(8);
		rd(STATUS_ADDR, 16'h0008);
		chk_oe(3'h0);
		uvf <= 1'b0;
		wt(8);
		rd(STATUS_ADDR, 16'h0008);
		uvr <= 1'b1;
		wait_oe();
		// Overcurrent with a retry while the short persists.
		short_en <= 1'b1;
		wt(6);
		chk_oe(3'h0);
		rd(FAULT_ADDR, 16'h0800);
		wait_oe();
		wt(8);
		chk_oe(3'h0);
		short_en <= 1'b0;
		wait_oe();
		wt(6);
		rd(FAULT_ADDR, 16'h0000);
		// Each lock detection method in turn.
		for (int i = 0; i < 3; i++) begin
			lock_sel <= 3'(1 << i);
			blocked  <= 1'b1;
			wt(6);
			chk_oe(3'h0);
			rd(STATUS_ADDR, 16'h0010 | 16'(1 << i));
			blocked <= 1'b0;
			wait_oe();
		end
		wt(1200);
		chk(16'(sine_bad), 16'h0000);
		end_of_test();
	end
endmodule : tb
